// >>> rtl/wdsp_consts.vh
// Constants for the watchdog service and power control block.
// Assumes a 20 MHz core clock that is also the oscillator clock.
`ifndef WDSP_CONSTS_VH
`define WDSP_CONSTS_VH

// ----------------------------------------------------------------------
// Register indices and byte addresses (byte address = index * 4)
// ----------------------------------------------------------------------
`define WDSP_ADDR_W 12
`define WDSP_IDX_PWR 10'h087
`define WDSP_IDX_SVC 10'h0a6
`define WDSP_IDX_PRESC 10'h0a7
`define WDSP_IDX_IRQ_STAT 10'h0b0
`define WDSP_IDX_IRQ_MASK 10'h0b1
`define WDSP_IDX_SERIAL 10'h0b2
`define WDSP_BA_PWR ({`WDSP_IDX_PWR, 2'b00})
`define WDSP_BA_SVC ({`WDSP_IDX_SVC, 2'b00})
`define WDSP_BA_PRESC ({`WDSP_IDX_PRESC, 2'b00})
`define WDSP_BA_IRQ_STAT ({`WDSP_IDX_IRQ_STAT, 2'b00})
`define WDSP_BA_IRQ_MASK ({`WDSP_IDX_IRQ_MASK, 2'b00})
`define WDSP_BA_SERIAL ({`WDSP_IDX_SERIAL, 2'b00})

// ----------------------------------------------------------------------
// Power control field positions and reset value
// ----------------------------------------------------------------------
`define WDSP_PWR_BAUD 7
`define WDSP_PWR_FRAMING 6
`define WDSP_PWR_COLD 4
`define WDSP_PWR_GF1 3
`define WDSP_PWR_GF0 2
`define WDSP_PWR_PD 1
`define WDSP_PWR_IDL 0
`define WDSP_PWR_RESET 8'h10
`define WDSP_SERIAL_SHARED 7
`define WDSP_PRESC_RESET 8'h00

// ----------------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------------
`define WDSP_IRQ_N 3
`define WDSP_IRQ_OVF 0
`define WDSP_IRQ_SVC 1
`define WDSP_IRQ_FE 2

// ----------------------------------------------------------------------
// Watchdog service bytes and timing
// ----------------------------------------------------------------------
`define WDSP_SVC_FIRST 8'h1e
`define WDSP_SVC_SECOND 8'he1
`define WDSP_WDT_LIMIT 14'h3fff
`define WDSP_MC_TOSC 4'hc
`define WDSP_CLK_PER_TOSC 1
`define WDSP_RST_PULSE_TOSC 96
`define WDSP_RST_PULSE_CYC (`WDSP_RST_PULSE_TOSC * `WDSP_CLK_PER_TOSC)

// ----------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------
`define WDSP_RESP_OKAY 2'b00
`define WDSP_RESP_SLVERR 2'b10

`endif

// >>> rtl/wdsp_axil_slave.v
// AXI4-Lite slave front end: one read and two writes in flight at most.
// Assumes the register file answers map hits combinationally.
`timescale 1ns/1ps
`include "wdsp_consts.vh"

module wdsp_axil_slave (
	input wire core_clk,
	input wire resetn,
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output wire wr_fire,
	output reg [11:0] wr_addr,
	output reg [31:0] wr_data,
	output reg [3:0] wr_strb,
	input wire wr_ok,
	output wire rd_fire,
	output reg [11:0] rd_addr,
	input wire [31:0] rd_data,
	input wire rd_ok
);
	reg aw_held;
	reg w_held;
	reg ar_held;

	// Write fires once address and data are both held, in either order
	assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
	assign rd_fire = ar_held & ~s_axi_rvalid;

	// ------------------------------------------------------------------
	// Write channels
	// ------------------------------------------------------------------
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr_addr <= 12'h000;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `WDSP_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				s_axi_awready <= 1'b0;
				wr_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				s_axi_wready <= 1'b0;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `WDSP_RESP_OKAY : `WDSP_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Read channels
	// ------------------------------------------------------------------
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_arready <= 1'b1;
			ar_held <= 1'b0;
			rd_addr <= 12'h000;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `WDSP_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				ar_held <= 1'b1;
				s_axi_arready <= 1'b0;
				rd_addr <= s_axi_araddr;
			end
			if (rd_fire) begin
				ar_held <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_ok ? `WDSP_RESP_OKAY : `WDSP_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule // wdsp_axil_slave

// >>> rtl/wdsp_wdt_core.v
// Watchdog unit: service sequence detector and machine-cycle counter.
// Assumes svc_wr is a one-cycle pulse per write to the service register.
`timescale 1ns/1ps
`include "wdsp_consts.vh"

module wdsp_wdt_core #(
	parameter [13:0] LIMIT = `WDSP_WDT_LIMIT,
	parameter [3:0] MC_CLKS = `WDSP_MC_TOSC
) (
	input wire core_clk,
	input wire resetn,
	input wire svc_wr,
	input wire [7:0] svc_data,
	output reg enabled,
	output reg overflow,
	output reg serviced
);
	localparam [3:0] MC_LAST = MC_CLKS - 4'h1;
	localparam [13:0] CNT_LAST = LIMIT - 14'h1;
	reg armed;
	reg [3:0] mc_cnt;
	reg [13:0] count;
	wire tick;
	wire fire;

	assign tick = enabled && (mc_cnt == MC_LAST);
	// Second byte counts only right after the first
	assign fire = svc_wr && armed && (svc_data == `WDSP_SVC_SECOND);

	// Sequence, enable and count; a service beats a same-cycle overflow
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			armed <= 1'b0;
			enabled <= 1'b0;
			mc_cnt <= 4'h0;
			count <= 14'h0000;
			overflow <= 1'b0;
			serviced <= 1'b0;
		end else begin
			overflow <= 1'b0;
			serviced <= fire;
			if (svc_wr)
				armed <= (svc_data == `WDSP_SVC_FIRST);
			if (fire) begin
				enabled <= 1'b1;
				mc_cnt <= 4'h0;
				count <= 14'h0000;
			end else if (enabled) begin
				mc_cnt <= tick ? 4'h0 : mc_cnt + 4'h1;
				if (tick && count == CNT_LAST) begin
					enabled <= 1'b0;
					count <= 14'h0000;
					overflow <= 1'b1;
				end else if (tick) begin
					count <= count + 14'h1;
				end
			end
		end
	end
endmodule // wdsp_wdt_core

// >>> rtl/wdsp_top.v
// Top of the watchdog service and power control block.
// Assumes event inputs come from logic on core_clk; por_n low only while
// the supply ramps, and resetn is held low whenever por_n is low.
// Overflow acts as an internal warm reset of power control and prescale only.
// Map and timing counts: wdsp_consts.vh
//
// Functional notes
// - Service register is write-only, reads zero
// - Bytes 1E then E1 enable or restart
// - Power-on reset sets the cold-start flag
// - Software may set or clear cold-start flag
// - Warm resets leave the cold-start flag alone
// - Framing select picks mode bit or error
// - Power control resets to 00X1 0000
// - Counter steps once per machine cycle
// - Count of 16383 fires 96-clock reset pulse
// - Watchdog off after reset; only overflow disables it
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`include "wdsp_consts.vh"

module wdsp_top #(
	parameter [13:0] WDT_LIMIT = `WDSP_WDT_LIMIT,
	parameter [3:0] MC_CLKS = `WDSP_MC_TOSC
) (
	input wire core_clk,
	input wire resetn,
	input wire por_n,
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire frame_error_event,
	input wire wake_event,
	output reg irq,
	output reg wdt_reset_out,
	output wire watchdog_enabled,
	output reg baud_doubler,
	output reg framing_select,
	output reg serial_mode_low,
	output reg frame_error_flag,
	output reg user_flag_one,
	output reg user_flag_zero,
	output reg powerdown_request,
	output reg idle_request,
	output reg cold_start_flag,
	output reg [7:0] watchdog_prescale_reg
);
	// ------------------------------------------------------------------
	// Derived timing
	// ------------------------------------------------------------------
	// Seven bits hold a count of 96
	localparam integer PULSE_FULL = `WDSP_RST_PULSE_CYC;
	localparam [6:0] PULSE_CYC = PULSE_FULL[6:0];

	// ------------------------------------------------------------------
	// Internal signals
	// ------------------------------------------------------------------
	// Bus side
	wire wr_fire;
	wire [11:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0] wr_strb;
	wire rd_fire;
	wire [11:0] rd_addr;
	reg [31:0] rd_data;
	reg rd_ok;
	wire wr_ok;
	wire byte0;
	wire wr_pwr;
	wire wr_svc;
	wire wr_presc;
	wire wr_mask;
	wire wr_serial;
	wire stat_clr;
	// Watchdog and interrupt side
	wire wdt_overflow;
	wire wdt_serviced;
	wire [2:0] irq_events;
	wire [2:0] next_irq_status;
	// Stored state
	reg [2:0] irq_status;
	reg [2:0] irq_mask;
	reg [6:0] pulse_cnt;

	// ------------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------------
	// Word match; low two address bits are ignored by the map
	function hit;
		input [11:0] addr;
		input [11:0] base;
		begin
			hit = (addr[11:2] == base[11:2]);
		end
	endfunction

	// True for any register of the map
	function mapped;
		input [11:0] addr;
		begin
			mapped = hit(addr, `WDSP_BA_PWR) |
				hit(addr, `WDSP_BA_SVC) |
				hit(addr, `WDSP_BA_PRESC) |
				hit(addr, `WDSP_BA_IRQ_STAT) |
				hit(addr, `WDSP_BA_IRQ_MASK) |
				hit(addr, `WDSP_BA_SERIAL);
		end
	endfunction

	// ------------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------------
	// Both answers come one edge after
	// the request is complete; unmapped: SLVERR
	wdsp_axil_slave u_slave (
		.core_clk(core_clk),
		.resetn(resetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_fire(wr_fire),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_ok(wr_ok),
		.rd_fire(rd_fire),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_ok(rd_ok)
	);

	// ------------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------------
	// Registers are one byte wide; lane 0 must be enabled to store
	// Upper data bits are ignored
	assign byte0 = wr_fire & wr_strb[0];
	assign wr_pwr = byte0 & hit(wr_addr, `WDSP_BA_PWR);
	assign wr_svc = byte0 & hit(wr_addr, `WDSP_BA_SVC);
	assign wr_presc = byte0 & hit(wr_addr, `WDSP_BA_PRESC);
	assign wr_mask = byte0 & hit(wr_addr, `WDSP_BA_IRQ_MASK);
	assign wr_serial = byte0 & hit(wr_addr, `WDSP_BA_SERIAL);
	// Lane 0 off: OKAY, nothing stored
	// Status is read-to-clear, so a write there is accepted and dropped
	assign wr_ok = mapped(wr_addr);

	// ------------------------------------------------------------------
	// Watchdog unit
	// ------------------------------------------------------------------
	// Stray service bytes disarm the
	// unit; other registers do not
	wdsp_wdt_core #(
		.LIMIT(WDT_LIMIT),
		.MC_CLKS(MC_CLKS)
	) u_wdt (
		.core_clk(core_clk),
		.resetn(resetn),
		.svc_wr(wr_svc),
		.svc_data(wr_data[7:0]),
		.enabled(watchdog_enabled),
		.overflow(wdt_overflow),
		.serviced(wdt_serviced)
	);

	// Overflow reset pulse; lasts exactly the pulse count in clocks
	// resetn low cuts the pulse short
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pulse_cnt <= 7'h00;
			wdt_reset_out <= 1'b0;
		end else if (wdt_overflow) begin
			pulse_cnt <= PULSE_CYC;
			wdt_reset_out <= 1'b1;
		end else if (pulse_cnt != 7'h00) begin
			pulse_cnt <= pulse_cnt - 7'h01;
			wdt_reset_out <= (pulse_cnt != 7'h01);
		end
	end

	// ------------------------------------------------------------------
	// Power control register
	// ------------------------------------------------------------------
	// Overflow acts as a warm reset of these bits, like the pin reset
	// Bit 5 has no storage
	// Low-power requests are flags only
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			baud_doubler <= 1'b0;
			framing_select <= 1'b0;
			user_flag_one <= 1'b0;
			user_flag_zero <= 1'b0;
			powerdown_request <= 1'b0;
			idle_request <= 1'b0;
		end else if (wdt_overflow) begin
			baud_doubler <= 1'b0;
			framing_select <= 1'b0;
			user_flag_one <= 1'b0;
			user_flag_zero <= 1'b0;
			powerdown_request <= 1'b0;
			idle_request <= 1'b0;
		end else if (wr_pwr) begin
			baud_doubler <= wr_data[`WDSP_PWR_BAUD];
			framing_select <= wr_data[`WDSP_PWR_FRAMING];
			user_flag_one <= wr_data[`WDSP_PWR_GF1];
			user_flag_zero <= wr_data[`WDSP_PWR_GF0];
			powerdown_request <= wr_data[`WDSP_PWR_PD];
			idle_request <= wr_data[`WDSP_PWR_IDL];
		end else if (wake_event) begin
			// A wake-up ends both low-power requests
			// A same-cycle write wins instead
			powerdown_request <= 1'b0;
			idle_request <= 1'b0;
		end
	end

	// Cold-start flag lives on the supply reset, so warm resets keep it
	// Release por_n only with resetn low
	always @(posedge core_clk or negedge por_n) begin
		if (!por_n)
			cold_start_flag <= 1'b1;
		else if (wr_pwr)
			cold_start_flag <= wr_data[`WDSP_PWR_COLD];
	end

	// ------------------------------------------------------------------
	// Shared serial control bit and prescale register
	// ------------------------------------------------------------------
	// Writes reach whichever bit the framing select currently exposes
	// The hidden bit keeps its value
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			serial_mode_low <= 1'b0;
			frame_error_flag <= 1'b0;
		end else begin
			if (wr_serial && !framing_select)
				serial_mode_low <= wr_data[`WDSP_SERIAL_SHARED];
			// Hardware set beats a same-cycle software clear
			if (frame_error_event)
				frame_error_flag <= 1'b1;
			else if (wr_serial && framing_select)
				frame_error_flag <= wr_data[`WDSP_SERIAL_SHARED];
		end
	end

	// Prescale field is stored only; its encoding is not modelled
	// Overflow restores the reset value
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			watchdog_prescale_reg <= `WDSP_PRESC_RESET;
		else if (wdt_overflow)
			watchdog_prescale_reg <= `WDSP_PRESC_RESET;
		else if (wr_presc)
			watchdog_prescale_reg <= wr_data[7:0];
	end

	// ------------------------------------------------------------------
	// Interrupt status, mask and output
	// ------------------------------------------------------------------
	// Bits: overflow, service, frame
	assign irq_events = {frame_error_event, wdt_serviced, wdt_overflow};
	// Only a fired read clears status
	assign stat_clr = rd_fire & hit(rd_addr, `WDSP_BA_IRQ_STAT);
	// New events survive the read that clears older ones
	assign next_irq_status = irq_events |
		(irq_status & ~{`WDSP_IRQ_N{stat_clr}});

	// Status, mask and registered interrupt level
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			irq_status <= 3'h0;
			irq_mask <= 3'h0;
			irq <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			if (wr_mask)
				irq_mask <= wr_data[2:0];
			// One clock behind status; keeps the pin glitch-free
			// Mask writes show one clock late
			irq <= |(irq_status & irq_mask);
		end
	end

	// ------------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------------
	// Captured at fire, so a status read
	// clears just the bits it returns
	always @* begin
		rd_data = 32'h0000_0000;
		rd_ok = mapped(rd_addr);
		if (hit(rd_addr, `WDSP_BA_PWR)) begin
			// Reserved bit 5 reads as zero
			rd_data[`WDSP_PWR_BAUD] = baud_doubler;
			rd_data[`WDSP_PWR_FRAMING] = framing_select;
			rd_data[`WDSP_PWR_COLD] = cold_start_flag;
			rd_data[`WDSP_PWR_GF1] = user_flag_one;
			rd_data[`WDSP_PWR_GF0] = user_flag_zero;
			rd_data[`WDSP_PWR_PD] = powerdown_request;
			rd_data[`WDSP_PWR_IDL] = idle_request;
		end else if (hit(rd_addr, `WDSP_BA_SVC)) begin
			rd_data = 32'h0000_0000;
		end else if (hit(rd_addr, `WDSP_BA_PRESC)) begin
			rd_data[7:0] = watchdog_prescale_reg;
		end else if (hit(rd_addr, `WDSP_BA_IRQ_STAT)) begin
			rd_data[2:0] = irq_status;
			rd_data[7] = watchdog_enabled;
		end else if (hit(rd_addr, `WDSP_BA_IRQ_MASK)) begin
			rd_data[2:0] = irq_mask;
		end else if (hit(rd_addr, `WDSP_BA_SERIAL)) begin
			rd_data[`WDSP_SERIAL_SHARED] = framing_select ?
				frame_error_flag : serial_mode_low;
		end else begin
			rd_ok = 1'b0;
		end
	end
endmodule // wdsp_top

// >>> verif/wdsp_monitor.sv
// Checker for the watchdog service and power control block.
// Sees only top-level ports; bound to every wdsp_top instance.
`timescale 1ns/1ps
`include "wdsp_consts.vh"

module wdsp_monitor (
	input wire core_clk,
	input wire resetn,
	input wire por_n,
	input wire s_axi_bvalid,
	input wire [1:0] s_axi_bresp,
	input wire frame_error_event,
	input wire irq,
	input wire wdt_reset_out,
	input wire watchdog_enabled,
	input wire framing_select,
	input wire frame_error_flag,
	input wire user_flag_one,
	input wire cold_start_flag,
	input wire [7:0] watchdog_prescale_reg
);
	// ------------------------------------------------------------------
	// Helper logic and sequences
	// ------------------------------------------------------------------
	// Length of the reset pulse, judged when it ends
	reg [7:0] pulse_cnt;
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			pulse_cnt <= 8'h00;
		else
			pulse_cnt <= wdt_reset_out ? pulse_cnt + 8'h01 : 8'h00;
	end

	sequence s_pulse_start;
		$rose(wdt_reset_out) ##1 wdt_reset_out [*8];
	endsequence

	sequence s_flags_cleared;
		!framing_select && !user_flag_one && watchdog_prescale_reg == 8'h00;
	endsequence

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	chk_pulse_len: assert property (
		$fell(wdt_reset_out) |-> pulse_cnt == `WDSP_RST_PULSE_CYC)
		else $error("reset pulse length wrong");
	chk_ovf_start: assert property (
		$fell(watchdog_enabled) |=> s_pulse_start)
		else $error("watchdog stopped without reset pulse");
	chk_ovf_clear: assert property (
		$rose(wdt_reset_out) |-> ##[0:1] s_flags_cleared)
		else $error("overflow left control bits set");
	chk_off_reset: assert property (
		$rose(resetn) |-> !watchdog_enabled && !wdt_reset_out && !irq)
		else $error("watchdog active after reset");
	chk_enable_cause: assert property (
		$rose(watchdog_enabled) |->
			s_axi_bvalid && s_axi_bresp == `WDSP_RESP_OKAY)
		else $error("watchdog started without a write");
	chk_fe_set: assert property (
		frame_error_event |=> frame_error_flag)
		else $error("frame error not recorded");
	// Cold flag belongs to the supply-on domain
	chk_warm_keep: assert property (disable iff (!por_n)
		!resetn && !$past(resetn) |-> $stable(cold_start_flag))
		else $error("warm reset changed cold flag");
	chk_cold_set: assert property (disable iff (!por_n)
		$rose(por_n) |-> cold_start_flag)
		else $error("cold flag not set by power-on");
endmodule // wdsp_monitor

bind wdsp_top wdsp_monitor chk_u (.*);

// >>> verif/test_wdsp_top.sv
// Self-checking bench for wdsp_top, driving AXI4-Lite and event pins.
// Assumes a short watchdog (limit 20, 2 clocks per machine cycle).
`timescale 1ns/1ps
`include "wdsp_consts.vh"

module test_wdsp_top;
	localparam [13:0] LIM = 14'h0014;
	localparam [3:0] MC = 4'h2;
	localparam [31:0] PM = 32'h0000_00df;
	localparam [31:0] B7 = 32'h0000_0080;
	reg core_clk, resetn, por_n, frame_error_event, wake_event;
	reg [11:0] s_axi_awaddr, s_axi_araddr;
	reg [31:0] s_axi_wdata;
	reg [3:0] s_axi_wstrb;
	reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	reg s_axi_rready;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, irq, wdt_reset_out, watchdog_enabled;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire baud_doubler, framing_select, serial_mode_low, frame_error_flag;
	wire user_flag_one, user_flag_zero, powerdown_request, idle_request;
	wire cold_start_flag;
	wire [7:0] watchdog_prescale_reg;
	logic [31:0] rdat;
	logic [1:0] resp;
	int err_total, n_compared, cyc, n_rst, i, n, n0;

	wdsp_top #(.WDT_LIMIT(LIM), .MC_CLKS(MC)) dut_u (.*);

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// ------------------------------------------------------------------
	// Reporting and bus tasks
	// ------------------------------------------------------------------
	task automatic fail(input string m);
		err_total++;
		$display("[FAIL] %0t %s", $time, m);
	endtask

	task automatic summarize;
		$display("Compared %0d, errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		if (got !== exp)
			err_total++;
	endtask

	// Write one byte; ends at a falling edge so outputs have settled
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= 32'(d);
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			k++;
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && k < 64);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (k >= 64)
			fail("write hang");
		@(negedge core_clk);
	endtask

	task automatic rd(input logic [11:0] a);
		int k;
		k = 0;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			k++;
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && k < 64);
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (k >= 64)
			fail("read hang");
		@(negedge core_clk);
	endtask

	task automatic rx(input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e);
		rd(a);
		cmp(rdat & m, e);
	endtask

	// One-cycle event pulse, then let irq follow
	task automatic ev(input bit fe);
		@(posedge core_clk);
		if (fe)
			frame_error_event <= 1'b1;
		else
			wake_event <= 1'b1;
		@(posedge core_clk);
		frame_error_event <= 1'b0;
		wake_event <= 1'b0;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
	endtask

	task automatic warm;
		@(posedge core_clk);
		resetn <= 1'b0;
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
	endtask

	// Hang guard and reset-pulse counter
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail("timeout");
			summarize;
		end
	end
	always @(posedge wdt_reset_out) n_rst++;

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		{resetn, por_n, frame_error_event, wake_event} = 4'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		s_axi_awaddr = 12'h000;
		s_axi_araddr = 12'h000;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hf;
		repeat (10) @(posedge core_clk);
		por_n <= 1'b1;
		@(posedge core_clk);
		resetn <= 1'b1;
		rx(`WDSP_BA_PWR, PM, 32'h0000_0010);
		rx(`WDSP_BA_SVC, 32'hffff_ffff, 32'h0000_0000);
		rx(`WDSP_BA_PRESC, 32'h0000_00ff, 32'h0000_0000);
		cmp(watchdog_enabled, 1'b0);
		rd(12'h004);
		cmp(resp, `WDSP_RESP_SLVERR);
		wr(12'h004, 8'h00);
		cmp(resp, `WDSP_RESP_SLVERR);
		// Cold flag cleared by software survives a warm reset
		wr(`WDSP_BA_PWR, 8'hef);
		cmp(resp, `WDSP_RESP_OKAY);
		rx(`WDSP_BA_PWR, PM, 32'h0000_00cf);
		cmp(cold_start_flag, 1'b0);
		cmp({baud_doubler, user_flag_zero}, 2'b11);
		warm();
		rx(`WDSP_BA_PWR, PM, 32'h0000_0000);
		wr(`WDSP_BA_PWR, 8'h13);
		cmp(cold_start_flag, 1'b1);
		warm();
		rx(`WDSP_BA_PWR, PM, 32'h0000_0010);
		wr(`WDSP_BA_PWR, 8'h13);
		ev(1'b0);
		cmp({powerdown_request, idle_request}, 2'b00);
		// Shared serial bit follows the framing select
		wr(`WDSP_BA_IRQ_MASK, 8'h00);
		wr(`WDSP_BA_SERIAL, 8'h80);
		cmp(serial_mode_low, 1'b1);
		ev(1'b1);
		cmp({frame_error_flag, irq}, 2'b10);
		rx(`WDSP_BA_SERIAL, B7, B7);
		wr(`WDSP_BA_PWR, 8'h50);
		wr(`WDSP_BA_SERIAL, 8'h00);
		cmp({frame_error_flag, serial_mode_low}, 2'b01);
		rx(`WDSP_BA_SERIAL, B7, 32'h0000_0000);
		wr(`WDSP_BA_PWR, 8'h10);
		rx(`WDSP_BA_SERIAL, B7, B7);
		rx(`WDSP_BA_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
		rx(`WDSP_BA_IRQ_STAT, 32'h0000_0007, 32'h0000_0000);
		wr(`WDSP_BA_IRQ_MASK, 8'h04);
		ev(1'b1);
		cmp(irq, 1'b1);
		rd(`WDSP_BA_IRQ_STAT);
		repeat (3) @(negedge core_clk);
		cmp(irq, 1'b0);
		// Prescale store, including a write with no byte strobe
		wr(`WDSP_BA_PRESC, 8'ha5);
		s_axi_wstrb <= 4'h0;
		wr(`WDSP_BA_PRESC, 8'hff);
		s_axi_wstrb <= 4'hf;
		cmp(watchdog_prescale_reg, 8'ha5);
		rx(`WDSP_BA_PRESC, 32'h0000_00ff, 32'h0000_00a5);
		wr(`WDSP_BA_PWR, 8'h5c);
		// Broken and interrupted sequences must not start it
		wr(`WDSP_BA_SVC, `WDSP_SVC_SECOND);
		wr(`WDSP_BA_SVC, `WDSP_SVC_FIRST);
		wr(`WDSP_BA_SVC, 8'h55);
		wr(`WDSP_BA_SVC, `WDSP_SVC_SECOND);
		cmp(watchdog_enabled, 1'b0);
		wr(`WDSP_BA_SVC, `WDSP_SVC_FIRST);
		wr(`WDSP_BA_SVC, `WDSP_SVC_SECOND);
		cmp(watchdog_enabled, 1'b1);
		wr(`WDSP_BA_SVC, 8'h00);
		cmp(watchdog_enabled, 1'b1);
		n0 = n_rst;
		for (i = 0; i < 5; i++) begin
			repeat (15) @(negedge core_clk);
			wr(`WDSP_BA_SVC, `WDSP_SVC_FIRST);
			wr(`WDSP_BA_SVC, `WDSP_SVC_SECOND);
		end
		cmp(n_rst, n0);
		// Left alone, it overflows and pulses the reset output
		n = 0;
		while (wdt_reset_out !== 1'b1 && n < 300) begin
			@(posedge core_clk);
			n++;
		end
		n_compared++;
		if (n < LIM * MC - 4 || n > LIM * MC + 4)
			fail("overflow time off");
		n = 0;
		while (wdt_reset_out === 1'b1 && n < 300) begin
			@(posedge core_clk);
			n++;
		end
		cmp(n, `WDSP_RST_PULSE_CYC);
		@(negedge core_clk);
		cmp(watchdog_enabled, 1'b0);
		rx(`WDSP_BA_PWR, PM, 32'h0000_0010);
		rx(`WDSP_BA_PRESC, 32'h0000_00ff, 32'h0000_0000);
		wr(`WDSP_BA_IRQ_MASK, 8'h01);
		repeat (3) @(negedge core_clk);
		cmp(irq, 1'b1);
		rx(`WDSP_BA_IRQ_STAT, 32'h0000_0083, 32'h0000_0003);
		repeat (3) @(negedge core_clk);
		cmp(irq, 1'b0);
		summarize;
	end
endmodule // test_wdsp_top
